// [hdl/scps_top.sv]
// Purpose: serial control port, status bytes, flow control, codec setup
// Assumes: host is spi mode 3 master; link logic runs on sclk
// Notes: sclk may stop between frames; chip select ends each frame
`timescale 1ns/10ps
`default_nettype none
module scps_top
  import scps_pkg::*;
#(
  parameter int BUSY_BYTES = 2
) (
  // system clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // serial link
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_flow_ready,
  output logic o_int_n,
  // core events and state
  input wire logic i_power_down,
  input wire logic i_mtx_fifo_half,
  input wire logic i_mtx_fifo_empty,
  input wire logic i_mrx_fifo_cond,
  input wire logic i_mrx_parity_err,
  input wire logic i_tone_valid,
  input wire logic i_ring_event,
  input wire scps_core_s i_core,
  input wire scps_setup_s i_live_setup,
  input wire logic i_sink_ready,
  // configuration and data to the core
  output scps_setup_s o_record_setup,
  output logic o_rate_override,
  output logic [2:0] o_play_rate,
  input wire logic [2:0] i_header_rate,
  output logic o_data_valid,
  output logic [7:0] o_data
);
  // ****************************************
  // link domain (sclk) shift logic
  // ****************************************
  logic cs_act;
  logic [2:0] bit_cnt_q;
  logic [6:0] shin_q;
  logic [7:0] shout_q;
  logic [7:0] cmd_q; // latched command byte
  logic [9:0] addr_q;
  scps_phase_e ph_q;
  logic byte_tgl_q; // toggles per completed byte outside the dead phase
  logic [7:0] byte_q; // completed byte, held for crossing
  logic [1:0] kind_q; // 0 cmd, 1 addr, 2 data
  logic viol_tgl_q; // toggles on a busy violation
  logic reject_q; // rejected byte blocks frame
  logic rdy_l; // ready seen in link domain
  logic [7:0] stat_l; // status seen in link domain
  logic [7:0] rdat_l; // read data seen in link domain
  logic [7:0] full_byte;
  logic byte_done;
  logic addr_lo_q; // next address byte is the low one
  logic viol_hit_q; // one violation report per frame
  logic viol_now; // busy violation seen at a byte edge
  logic [7:0] load_byte; // byte loaded into the output shifter
  assign cs_act = ~i_chip_select_n;
  // the stale ready copy may only fall during the byte, so look at both ends
  assign viol_now = (bit_cnt_q == 3'd0 || byte_done) && ph_q == PH_DATA && !rdy_l &&
                    cmd_q == CMD_DATA_WRITE && !viol_hit_q;
  assign full_byte = {shin_q, i_mosi};
  assign byte_done = (bit_cnt_q == 3'd7);
  // chip select high resets the framing, so each frame begins clean
  always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      bit_cnt_q <= 3'd0;
      shin_q <= 7'h00;
      ph_q <= PH_CMD;
      reject_q <= 1'b0;
      addr_lo_q <= 1'b0;
      viol_hit_q <= 1'b0;
    end else begin
      if (viol_now)
        viol_hit_q <= 1'b1;
      bit_cnt_q <= bit_cnt_q + 3'd1;
      shin_q <= full_byte[6:0]; // msb first
      if (byte_done) begin
        unique case (ph_q)
          PH_CMD: ph_q <= (full_byte == CMD_REG_WRITE || full_byte == CMD_REG_READ)
                          ? PH_ADDR : PH_DATA;
          PH_ADDR: ph_q <= addr_lo_q ? PH_DATA : PH_ADDR;
          PH_DATA: ph_q <= (reject_q || (!rdy_l && cmd_q == CMD_DATA_WRITE))
                          ? PH_DEAD : PH_DATA;
          PH_DEAD: ph_q <= PH_DEAD;
        endcase
        if (ph_q == PH_ADDR)
          addr_lo_q <= 1'b1;
        if (ph_q == PH_DATA && !rdy_l && cmd_q == CMD_DATA_WRITE)
          reject_q <= 1'b1;
      end
    end
  end
  // command and address capture; these survive chip select for the core side
  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_q <= 8'h00;
      addr_q <= 10'h000;
      byte_tgl_q <= 1'b0;
      byte_q <= 8'h00;
      kind_q <= 2'd0;
      viol_tgl_q <= 1'b0;
    end else if (cs_act) begin
      if (byte_done && ph_q != PH_DEAD) begin
        byte_q <= full_byte;
        byte_tgl_q <= ~byte_tgl_q;
        kind_q <= (ph_q == PH_CMD) ? 2'd0 : (ph_q == PH_ADDR) ? 2'd1 : 2'd2;
        if (ph_q == PH_CMD)
          cmd_q <= full_byte;
        if (ph_q == PH_ADDR)
          addr_q <= {addr_q[1:0], full_byte};
      end
      // first or last clock of a data write byte while busy is a violation
      if (viol_now)
        viol_tgl_q <= ~viol_tgl_q;
    end
  end
  // output shifter on falling edge; loads status or read data at byte start
  always_ff @(negedge i_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      shout_q <= 8'h00;
    end else if (bit_cnt_q == 3'd0) begin
      shout_q <= load_byte;
    end else begin
      shout_q <= {shout_q[6:0], 1'b0};
    end
  end
  // the first status bit must be on the wire before the first edge
  assign load_byte = (ph_q == PH_DATA && cmd_q != CMD_DATA_WRITE && cmd_q != CMD_REG_WRITE)
                     ? rdat_l : stat_l;
  // read data needs its own msb up front, not the status msb
  assign o_miso = (bit_cnt_q == 3'd0) ? load_byte[7] : shout_q[7];
  assign o_miso_oe = cs_act & ~i_power_down;
  // ****************************************
  // crossings into the link domain (levels)
  // ****************************************
  logic [7:0] stat_q;
  logic [7:0] rdat_q;
  logic ready_q;
  scps_sync #(.W(1)) u_to_link (
    .i_clock(i_sclk),
    .i_arst_n(i_arst_n),
    .i_level(ready_q),
    .o_level(rdy_l)
  );
  // sclk stops between bytes, so a synchroniser would hold stale bytes;
  // status and read data settle within the byte gap and are loaded directly
  assign stat_l = stat_q;
  assign rdat_l = rdat_q;
  // ****************************************
  // crossings into the system domain
  // ****************************************
  logic byte_tgl_s;
  logic viol_tgl_s;
  logic byte_seen_q;
  logic viol_seen_q;
  scps_sync #(.W(2)) u_to_sys (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_level({byte_tgl_q, viol_tgl_q}),
    .o_level({byte_tgl_s, viol_tgl_s})
  );
  // byte_q and kind_q are stable two edges before the toggle is seen
  logic byte_evt;
  logic viol_evt;
  assign byte_evt = byte_tgl_s ^ byte_seen_q;
  assign viol_evt = viol_tgl_s ^ viol_seen_q;
  // ****************************************
  // registers and status
  // ****************************************
  logic [7:0] setup_q;
  logic [7:0] pbc_q;
  logic [3:0] busy_cnt_q;
  logic [3:0] evt_q;
  logic timer_q;
  logic ovf_q;
  logic [7:0] cmd_s;
  logic wr_reg;
  logic is_data_wr;
  logic clear_cmd;
  logic [3:0] evt_in;
  logic any_flag;
  logic [7:0] setup_rd;
  logic [7:0] extra_byte;
  logic [7:0] int2_byte;
  assign evt_in[I2_MTX_BIT-4] = i_mtx_fifo_half | i_mtx_fifo_empty;
  assign evt_in[I2_MRX_BIT-4] = i_mrx_fifo_cond | i_mrx_parity_err;
  assign evt_in[I2_SIG_BIT-4] = i_tone_valid;
  assign evt_in[I2_RING_BIT-4] = i_ring_event;
  assign int2_byte = {evt_q, 4'h0};
  assign any_flag = (|evt_q) | timer_q | ovf_q;
  assign o_int_n = ~any_flag;
  assign wr_reg = byte_evt && kind_q == 2'd2 && cmd_s == CMD_REG_WRITE;
  assign is_data_wr = byte_evt && kind_q == 2'd2 && cmd_s == CMD_DATA_WRITE;
  assign clear_cmd = byte_evt && kind_q == 2'd0 && byte_q == CMD_CLEAR_FLAGS;
  // live readback when selected
  assign setup_rd = pbc_q[PBC_LIVE_READ_BIT] ? {i_live_setup.rate, i_live_setup.algo} : setup_q;
  assign extra_byte = {i_core.timer_tick | timer_q, 2'b00, i_core.fsync_locked, 1'b0,
                       i_core.synth_locked, i_core.decoding, i_core.active};
  // record setup and playback rate selection
  assign o_record_setup = scps_setup_s'(setup_q);
  assign o_rate_override = pbc_q[PBC_RATE_OVR_BIT];
  // rate code 7 passes through untouched; the core treats it as don't care
  assign o_play_rate = pbc_q[PBC_RATE_OVR_BIT] ? setup_q[RATE_MSB:RATE_LSB]
                                               : i_header_rate;
  // toggle trackers and command copy
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      byte_seen_q <= 1'b0;
      viol_seen_q <= 1'b0;
      cmd_s <= 8'h00;
    end else begin
      byte_seen_q <= byte_tgl_s;
      viol_seen_q <= viol_tgl_s;
      if (byte_evt && kind_q == 2'd0)
        cmd_s <= byte_q;
    end
  end
  // register writes; the full 10-bit address decodes here
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      setup_q <= CODEC_SETUP_RST;
      pbc_q <= PLAYBACK_CTRL_RST;
    end else if (wr_reg) begin
      if (addr_q == CODEC_SETUP_OFS)
        setup_q <= byte_q;
      if (addr_q == PLAYBACK_CTRL_OFS)
        pbc_q <= byte_q;
    end
  end
  // sticky flags: an event in the clearing cycle survives
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      evt_q <= 4'h0;
      timer_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      evt_q <= (clear_cmd ? 4'h0 : evt_q) | evt_in;
      timer_q <= (clear_cmd ? 1'b0 : timer_q) | i_core.timer_tick;
      ovf_q <= (clear_cmd ? 1'b0 : ovf_q) | viol_evt;
    end
  end
  // busy after each accepted data byte; changes only after its last bit
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_cnt_q <= 4'h0;
    end else if (is_data_wr) begin
      busy_cnt_q <= 4'(BUSY_BYTES);
    end else if (busy_cnt_q != 4'h0 && i_sink_ready) begin
      busy_cnt_q <= busy_cnt_q - 4'h1;
    end
  end
  // data handed to the core for each accepted write byte
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data_valid <= 1'b0;
      o_data <= 8'h00;
    end else begin
      o_data_valid <= is_data_wr && ready_q;
      if (is_data_wr)
        o_data <= byte_q;
    end
  end
  // ready and status byte; ready bit mirrors the pin
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ready_q <= 1'b0;
      stat_q <= 8'h00;
      rdat_q <= 8'h00;
    end else begin
      ready_q <= ~i_power_down && busy_cnt_q == 4'h0 && !is_data_wr;
      stat_q <= 8'h00;
      stat_q[ST_PD_BIT] <= i_power_down;
      stat_q[ST_RDY_BIT] <= ready_q & ~i_power_down;
      stat_q[ST_INT_BIT] <= any_flag;
      unique case (cmd_s)
        CMD_READ_EXTRA: rdat_q <= extra_byte;
        CMD_READ_STATUS: rdat_q <= int2_byte | {4'h0, ovf_q, 3'b000};
        CMD_REG_READ: rdat_q <= (addr_q == CODEC_SETUP_OFS) ? setup_rd
                                : (addr_q == PLAYBACK_CTRL_OFS) ? pbc_q : 8'h00;
        default: rdat_q <= 8'h00;
      endcase
    end
  end
  assign o_flow_ready = ready_q; // host pauses on low
endmodule
`default_nettype wire

// [hdl/scps_pkg.sv]
// Purpose: shared constants and types for the serial control port status block
// Assumes: 8-bit register data, 10-bit register offsets
// Notes: status byte layouts and codec setup encodings
package scps_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [9:0] CODEC_SETUP_OFS = 10'h000;
  localparam logic [9:0] PLAYBACK_CTRL_OFS = 10'h001;
  localparam logic [7:0] CODEC_SETUP_RST = 8'h64;
  localparam logic [7:0] PLAYBACK_CTRL_RST = 8'h00;
  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 5;
  localparam int ALGO_MSB = 4;
  localparam int ALGO_LSB = 0;
  localparam int PBC_RATE_OVR_BIT = 0;
  localparam int PBC_LIVE_READ_BIT = 4;
  // ****************************************
  // status byte bit positions
  // ****************************************
  localparam int ST_PD_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_INT_BIT = 5;
  localparam int XS_TIMER_BIT = 7;
  localparam int XS_FSYNC_BIT = 4;
  localparam int XS_SYNTH_BIT = 2;
  localparam int XS_DIR_BIT = 1;
  localparam int XS_ACT_BIT = 0;
  localparam int I2_RING_BIT = 7;
  localparam int I2_SIG_BIT = 6;
  localparam int I2_MRX_BIT = 5;
  localparam int I2_MTX_BIT = 4;
  localparam int I1_OVF_BIT = 3;
  // ****************************************
  // codec algorithm codes
  // ****************************************
  localparam logic [4:0] ALG_ADPCM2 = 5'h02;
  localparam logic [4:0] ALG_ADPCM5 = 5'h05;
  localparam logic [4:0] ALG_MULAW6 = 5'h10;
  localparam logic [4:0] ALG_MULAW8 = 5'h12;
  localparam logic [4:0] ALG_DMULAW6 = 5'h14;
  localparam logic [4:0] ALG_DMULAW8 = 5'h16;
  localparam logic [4:0] ALG_PCM8 = 5'h18;
  localparam logic [4:0] ALG_PCM10 = 5'h19;
  localparam logic [4:0] ALG_PCM12 = 5'h1B;
  localparam logic [2:0] RATE_MAX_CODE = 3'h6;
  // ****************************************
  // commands of this port (serial opcodes)
  // ****************************************
  localparam logic [7:0] CMD_READ_STATUS = 8'h40;
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h46;
  localparam logic [7:0] CMD_READ_EXTRA = 8'h48;
  localparam logic [7:0] CMD_REG_WRITE = 8'hB8;
  localparam logic [7:0] CMD_REG_READ = 8'hBA;
  localparam logic [7:0] CMD_DATA_WRITE = 8'hA0;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic ring;
    logic signal_tone;
    logic modem_rx;
    logic modem_tx;
  } scps_evt_s;
  typedef struct packed {
    logic timer_tick;
    logic fsync_locked;
    logic synth_locked;
    logic decoding;
    logic active;
  } scps_core_s;
  typedef struct packed {
    logic [2:0] rate;
    logic [4:0] algo;
  } scps_setup_s;
  // serial link phases
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b11,
    PH_DEAD = 2'b10
  } scps_phase_e;
endpackage

// [hdl/scps_sync.sv]
// Purpose: two flip-flop level synchroniser
// Assumes: input is a level from another clock domain
// Notes: first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module scps_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // level in and out
  input wire logic [W-1:0] i_level,
  output logic [W-1:0] o_level
);
  logic [W-1:0] meta_q; // first stage, read only by second
  logic [W-1:0] sync_q; // second stage
  // ****************************************
  // two stage capture
  // ****************************************
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_level;
      sync_q <= meta_q;
    end
  end
  assign o_level = sync_q;
endmodule
`default_nettype wire

// [verification/scps_properties.sv]
// Purpose: port checks of the serial control port
// Assumes: all checked relations live in the system clock domain
// Notes: bound onto every instance of the top
`timescale 1ns/10ps
`default_nettype none
module scps_properties
  import scps_pkg::*;
#(
  parameter int BUSY_BYTES = 2
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // watched inputs
  input wire logic i_chip_select_n,
  input wire logic i_power_down,
  input wire logic i_mtx_fifo_half,
  input wire logic i_mtx_fifo_empty,
  input wire logic i_mrx_fifo_cond,
  input wire logic i_mrx_parity_err,
  input wire logic i_tone_valid,
  // watched outputs
  input wire logic o_miso_oe,
  input wire logic o_flow_ready,
  input wire logic o_int_n,
  input wire scps_setup_s o_record_setup,
  input wire logic o_rate_override,
  input wire logic [2:0] o_play_rate
);
  // ****
  // checks
  // ****
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  setup_reset_a: assert property (
    $rose(i_arst_n) |-> o_record_setup == CODEC_SETUP_RST)
    else $error("codec setup not at reset value");
  play_override_a: assert property (
    o_rate_override |-> o_play_rate == o_record_setup.rate)
    else $error("override does not pick the setup rate");
  deselect_quiet_a: assert property (
    i_chip_select_n && $past(i_chip_select_n) |-> !o_miso_oe)
    else $error("serial out driven while deselected");
  mtx_int_a: assert property (
    i_mtx_fifo_half || i_mtx_fifo_empty |-> ##[1:6] !o_int_n)
    else $error("modem tx event gave no interrupt");
  mrx_int_a: assert property (
    i_mrx_fifo_cond || i_mrx_parity_err |-> ##[1:6] !o_int_n)
    else $error("modem rx event gave no interrupt");
  tone_int_a: assert property (
    i_tone_valid |-> ##[1:6] !o_int_n)
    else $error("tone event gave no interrupt");
  int_hold_a: assert property (
    $fell(o_int_n) |=> !o_int_n [*3])
    else $error("interrupt did not hold");
  pd_ready_a: assert property (
    i_power_down |-> ##[0:4] !o_flow_ready)
    else $error("ready high while powered down");
endmodule
bind scps_top scps_properties #(.BUSY_BYTES(BUSY_BYTES)) u_props (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_chip_select_n(i_chip_select_n),
  .i_power_down(i_power_down), .i_mtx_fifo_half(i_mtx_fifo_half),
  .i_mtx_fifo_empty(i_mtx_fifo_empty), .i_mrx_fifo_cond(i_mrx_fifo_cond),
  .i_mrx_parity_err(i_mrx_parity_err), .i_tone_valid(i_tone_valid),
  .o_miso_oe(o_miso_oe), .o_flow_ready(o_flow_ready), .o_int_n(o_int_n),
  .o_record_setup(o_record_setup), .o_rate_override(o_rate_override),
  .o_play_rate(o_play_rate)
);
`default_nettype wire

// [verification/scps_host.sv]
// Purpose: spi mode 3 host model for the serial control port
// Assumes: link clock period 32 ns, stands high between frames
// Notes: data line shows the inverse of its last bit once released
`timescale 1ns/10ps
`default_nettype none
module scps_host (
  // link out
  output logic o_sclk,
  output logic o_chip_select_n,
  output logic o_mosi,
  // link in
  input wire logic i_miso,
  input wire logic i_flow_ready,
  // byte seen back
  output logic o_done,
  output logic [7:0] o_rx
);
  initial begin
    o_sclk = 1'b1;
    o_chip_select_n = 1'b1;
    o_mosi = 1'b0;
    o_done = 1'b0;
    o_rx = 8'h00;
  end
  // a frame starts at the select fall
  task automatic open_frame();
    o_chip_select_n = 1'b0;
    #40;
  endtask
  // ending the frame is also how a rejected write is abandoned
  task automatic close_frame();
    #40;
    o_chip_select_n = 1'b1;
    o_mosi = ~o_mosi;
    #200;
  endtask
  // one byte msb first; when pacing, clock stays high while busy
  task automatic xfer(input logic [7:0] tx, input bit pace);
    int n;
    n = 0;
    while (pace && i_flow_ready !== 1'b1 && n < 2000) begin
      #8;
      n++;
    end
    // let the registered status ready bit catch up with the pin
    if (pace)
      #48;
    for (int i = 7; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_mosi = tx[i];
      #16;
      o_sclk = 1'b1;
      o_rx[i] = i_miso;
      #16;
    end
    o_done = 1'b1;
    #1;
    o_done = 1'b0;
    #320;
  endtask
endmodule
`default_nettype wire

// [verification/scps_top_tb.sv]
// Purpose: self-checking bench of the serial control port
// Assumes: host model drives the link; system clock 25 MHz
// Notes: link bytes are compared in order against a queue of notes
`timescale 1ns/10ps
`default_nettype none
module scps_top_tb;
  import scps_pkg::*;
  // ****
  // nets and bench state
  // ****
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic power_down = 1'b0;
  logic sink_ready = 1'b1;
  logic [5:0] ev = 6'h00; // tx half, tx empty, rx cond, parity, tone, ring
  scps_core_s core = '0;
  scps_setup_s live = '0;
  logic [2:0] hdr_rate = 3'h0;
  wire logic sclk, cs_n, mosi, miso, miso_oe, flow_ready, int_n, rate_ovr, data_valid, done;
  wire logic [2:0] play_rate;
  wire logic [7:0] data, rx;
  wire scps_setup_s rec;
  int failures = 0;
  int comparisons = 0;
  int beats = 0;
  logic [15:0] notes [$]; // {mask, expected}
  logic [15:0] note;
  logic [7:0] v;
  logic tick_seen = 1'b0; // timer flag is sticky until cleared
  logic [4:0] algos [13] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h10, 5'h11, 5'h12,
                             5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1B};
  int ev_bit [6] = '{I2_MTX_BIT, I2_MTX_BIT, I2_MRX_BIT, I2_MRX_BIT, I2_SIG_BIT, I2_RING_BIT};
  always #20 clock = ~clock;
  scps_top #(.BUSY_BYTES(2)) uut (
    .i_clock(clock), .i_arst_n(arst_n), .i_sclk(sclk), .i_chip_select_n(cs_n),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .o_flow_ready(flow_ready),
    .o_int_n(int_n), .i_power_down(power_down), .i_mtx_fifo_half(ev[0]),
    .i_mtx_fifo_empty(ev[1]), .i_mrx_fifo_cond(ev[2]), .i_mrx_parity_err(ev[3]),
    .i_tone_valid(ev[4]), .i_ring_event(ev[5]), .i_core(core), .i_live_setup(live),
    .i_sink_ready(sink_ready), .o_record_setup(rec), .o_rate_override(rate_ovr),
    .o_play_rate(play_rate), .i_header_rate(hdr_rate), .o_data_valid(data_valid),
    .o_data(data)
  );
  // an undriven serial out is shown as a toggling pattern
  scps_host host (
    .o_sclk(sclk), .o_chip_select_n(cs_n), .o_mosi(mosi), .i_miso(miso_oe ? miso : sclk),
    .i_flow_ready(flow_ready), .o_done(done), .o_rx(rx)
  );
  // ****
  // tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // note the expected byte, then shift it through the host
  task automatic xb(input logic [7:0] tx, input logic [7:0] m, input logic [7:0] e, input bit p);
    notes.push_back({m, e});
    host.xfer(tx, p);
  endtask
  task automatic cmd2(input logic [7:0] c, input logic [7:0] sm, input logic [7:0] se,
                      input logic [7:0] m, input logic [7:0] e);
    host.open_frame();
    xb(c, sm, se, 1'b0);
    xb(8'h00, m, e, 1'b0);
    host.close_frame();
  endtask
  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    host.open_frame();
    xb(CMD_REG_WRITE, 8'h00, 8'h00, 1'b0);
    xb({6'h00, a[9:8]}, 8'h00, 8'h00, 1'b0);
    xb(a[7:0], 8'h00, 8'h00, 1'b0);
    xb(d, 8'h00, 8'h00, 1'b0);
    host.close_frame();
  endtask
  task automatic reg_rd(input logic [9:0] a, input logic [7:0] e);
    host.open_frame();
    xb(CMD_REG_READ, 8'hE0, 8'h40, 1'b0);
    xb({6'h00, a[9:8]}, 8'h00, 8'h00, 1'b0);
    xb(a[7:0], 8'h00, 8'h00, 1'b0);
    xb(8'h00, 8'hFF, e, 1'b0);
    host.close_frame();
  endtask
  // bounded wait; a stuck busy line is reported, not hung on
  task automatic wait_ready();
    int n;
    n = 0;
    while (flow_ready !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    chk({7'h00, flow_ready}, 8'h01);
  endtask
  task automatic stop_test();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****
  // monitors
  // ****
  always @(posedge done) begin
    note = notes.pop_front();
    if (note[15:8] != 8'h00) chk(rx & note[15:8], note[7:0]);
  end
  always @(posedge clock) if (data_valid === 1'b1) beats++;
  // whole sequence needs well under a millisecond
  initial begin
    #3_000_000;
    failures++;
    stop_test();
  end
  // ****
  // sequence
  // ****
  initial begin
    void'($urandom(32'hb7d9));
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    wait_ready();
    reg_rd(CODEC_SETUP_OFS, CODEC_SETUP_RST);
    $display("reset test done");
    for (int k = 0; k < 13; k++) begin
      v = {3'(k % 7), algos[k]};
      reg_wr(CODEC_SETUP_OFS, v);
      reg_rd(CODEC_SETUP_OFS, v);
      chk(rec, v);
    end
    $display("codec code test done");
    @(posedge clock);
    live <= 8'($urandom);
    hdr_rate <= 3'($urandom);
    reg_wr(PLAYBACK_CTRL_OFS, 8'h11);
    reg_rd(CODEC_SETUP_OFS, live);
    chk({5'h00, play_rate}, {5'h00, v[7:5]});
    reg_wr(PLAYBACK_CTRL_OFS, 8'h00);
    repeat (8) @(posedge clock);
    chk({5'h00, play_rate}, {5'h00, hdr_rate});
    $display("playback control test done");
    repeat (4) begin
      @(posedge clock);
      core <= 5'($urandom);
      repeat (8) @(posedge clock);
      tick_seen = tick_seen | core.timer_tick;
      v = {tick_seen, 2'b00, core.fsync_locked, 1'b0, core.synth_locked,
           core.decoding, core.active};
      cmd2(CMD_READ_EXTRA, 8'h00, 8'h00, 8'h97, v);
    end
    @(posedge clock);
    core <= '0;
    repeat (2) @(posedge clock);
    cmd2(CMD_CLEAR_FLAGS, 8'h00, 8'h00, 8'h00, 8'h00);
    $display("extra status test done");
    for (int e = 0; e < 6; e++) begin
      @(posedge clock);
      ev <= 6'(1 << e);
      @(posedge clock);
      ev <= 6'h00;
      repeat (8) @(posedge clock);
      chk({7'h00, int_n}, 8'h00);
      v = 8'(1 << ev_bit[e]);
      cmd2(CMD_READ_STATUS, 8'h20, 8'h20, v, v);
      cmd2(CMD_CLEAR_FLAGS, 8'h00, 8'h00, 8'h00, 8'h00);
      repeat (8) @(posedge clock);
      chk({7'h00, int_n}, 8'h01);
    end
    $display("event flag test done");
    host.open_frame();
    xb(CMD_DATA_WRITE, 8'h00, 8'h00, 1'b0);
    repeat (3) xb(8'($urandom), 8'h40, 8'h40, 1'b1);
    host.close_frame();
    chk({7'h00, int_n}, 8'h01);
    @(posedge clock);
    sink_ready <= 1'b0;
    host.open_frame();
    xb(CMD_DATA_WRITE, 8'h00, 8'h00, 1'b0);
    xb(8'($urandom), 8'h40, 8'h40, 1'b1);
    xb(8'($urandom), 8'h40, 8'h00, 1'b0);
    host.close_frame();
    repeat (8) @(posedge clock);
    chk({7'h00, int_n}, 8'h00);
    cmd2(CMD_READ_STATUS, 8'h20, 8'h20, 8'h08, 8'h08);
    chk(8'(beats), 8'h04);
    @(posedge clock);
    sink_ready <= 1'b1;
    wait_ready();
    cmd2(CMD_CLEAR_FLAGS, 8'h00, 8'h00, 8'h00, 8'h00);
    $display("flow control test done");
    @(posedge clock);
    power_down <= 1'b1;
    repeat (8) @(posedge clock);
    chk({7'h00, flow_ready}, 8'h00);
    power_down <= 1'b0;
    wait_ready();
    $display("power down test done");
    stop_test();
  end
endmodule
`default_nettype wire
